// ### hw/ccd_decoder.sv
// Instruction decoder, text and glyph memories and cell renderer
// --------------------------------------------------------------------
// --------------------------------------------------------------------
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module ccd_decoder #(
	parameter int unsigned BLINK_HALF = ccd_pkg::BLINK_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ccd_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [4:0] scanCol,
	input wire logic scanLine,
	input wire logic [2:0] scanRow,
	output logic [4:0] pixelRow,
	output logic [7:0] fontCode,
	output logic fontLookup,
	output logic busWidthSelect,
	output logic lineCount,
	output logic brightnessHigh,
	output logic brightnessLow
);
	import ccd_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] stepPtr(input logic [6:0] p, input logic up,
		input logic glyph);
		logic [6:0] r;
		if (glyph) begin
			r = {1'b0, up ? p[5:0] + 6'h1 : p[5:0] - 6'h1};
		end else if (up) begin
			r = (p == TEXT_L1_LAST) ? TEXT_L2_FIRST :
				(p == TEXT_L2_LAST) ? TEXT_L1_FIRST : p + 7'h1;
		end else begin
			r = (p == TEXT_L2_FIRST) ? TEXT_L1_LAST :
				(p == TEXT_L1_FIRST) ? TEXT_L2_LAST : p - 7'h1;
		end
		return r;
	endfunction

	// Left shift shows the next address in the first cell
	function automatic logic [5:0] stepShift(input logic [5:0] s, input logic left);
		logic [5:0] r;
		if (left) begin
			r = (s == LAST_CELL) ? 6'h0 : s + 6'h1;
		end else begin
			r = (s == 6'h0) ? LAST_CELL : s - 6'h1;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] textRam [TEXT_DEPTH];
	logic [7:0] glyphRam [GLYPH_DEPTH];
	ccd_state_e state, next_state;
	logic [6:0] clearIdx, next_clearIdx;
	logic [6:0] addressPointer, next_addressPointer;
	logic glyphSel, next_glyphSel;
	logic incMode, next_incMode;
	logic shiftEn, next_shiftEn;
	logic displayOn, next_displayOn;
	logic cursorOn, next_cursorOn;
	logic blinkOn, next_blinkOn;
	logic next_busWidthSelect, next_lineCount;
	logic [1:0] brightness, next_brightness;
	logic [5:0] displayShift, next_displayShift;
	logic rdDone, next_rdDone;
	logic [31:0] next_prdata;
	logic [31:0] blinkCnt, next_blinkCnt;
	logic blinkPhase, next_blinkPhase;
	logic [4:0] next_pixelRow;
	logic [7:0] next_fontCode;
	logic next_fontLookup;

	logic textWe, glyphWe;
	logic [6:0] textWaddr;
	logic [7:0] textWdata;
	logic bufInValid, bufInReady, bufOutValid, bufOutReady;
	logic [BUF_WIDTH-1:0] bufOutData;
	logic [7:0] cmdByte;
	logic registerSelect;
	logic isInstr, isData, isStatus, mapped, wrAccess, rdAccess, drained, rdFinish;
	logic [31:0] statusWord;

	// ----------------------------------------------------------------
	// Host port
	// ----------------------------------------------------------------
	assign isInstr = (paddr == ADDR_INSTR);
	assign isData = (paddr == ADDR_DATA);
	assign isStatus = (paddr == ADDR_STATUS);
	assign mapped = isInstr || isData || isStatus;
	assign wrAccess = psel && penable && pwrite;
	assign rdAccess = psel && penable && !pwrite;
	assign drained = !bufOutValid && (state == ST_IDLE);
	assign bufInValid = wrAccess && (isInstr || isData);
	assign rdFinish = rdAccess && isData && rdDone;
	assign pslverr = psel && penable && !mapped;
	assign cmdByte = bufOutData[7:0];
	assign registerSelect = bufOutData[8];
	assign bufOutReady = (state == ST_IDLE);
	assign brightnessHigh = brightness[1];
	assign brightnessLow = brightness[0];

	// Full buffer holds the write access open
	always_comb begin
		if (bufInValid) begin
			pready = bufInReady;
		end else if (rdAccess && mapped) begin
			pready = rdDone;
		end else begin
			pready = 1'b1;
		end
	end

	always_comb begin
		statusWord = '0;
		statusWord[STAT_PTR_LSB +: 7] = addressPointer;
		statusWord[STAT_GLYPH_SEL] = glyphSel;
		statusWord[STAT_INC] = incMode;
		statusWord[STAT_SHIFT_EN] = shiftEn;
		statusWord[STAT_DISP] = displayOn;
		statusWord[STAT_CURSOR] = cursorOn;
		statusWord[STAT_BLINK] = blinkOn;
		statusWord[STAT_BUS_W] = busWidthSelect;
		statusWord[STAT_LINES] = lineCount;
		statusWord[STAT_BRIGHT_LSB +: 2] = brightness;
		statusWord[STAT_SHIFT_LSB +: 6] = displayShift;
	end

	// Reads wait for queued writes so they see their effect
	always_comb begin
		next_rdDone = 1'b0;
		next_prdata = prdata;
		if (rdAccess && mapped && drained && !rdDone) begin
			next_rdDone = 1'b1;
			if (isInstr) begin
				next_prdata = {24'h0, BUSY_FLAG, addressPointer};
			end else if (isData) begin
				next_prdata = {24'h0, glyphSel ? glyphRam[addressPointer[5:0]] :
					textRam[addressPointer]};
			end else begin
				next_prdata = statusWord;
			end
		end
	end

	ccd_buffer #(
		.WIDTH(BUF_WIDTH),
		.DEPTH(BUF_DEPTH)
	) ccd_buffer_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.inData({isData, pwdata[7:0]}),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.outData(bufOutData),
		.outValid(bufOutValid),
		.outReady(bufOutReady)
	);

	// ----------------------------------------------------------------
	// Decoder
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_clearIdx = clearIdx;
		next_addressPointer = addressPointer;
		next_glyphSel = glyphSel;
		next_incMode = incMode;
		next_shiftEn = shiftEn;
		next_displayOn = displayOn;
		next_cursorOn = cursorOn;
		next_blinkOn = blinkOn;
		next_busWidthSelect = busWidthSelect;
		next_lineCount = lineCount;
		next_brightness = brightness;
		next_displayShift = displayShift;
		textWe = 1'b0;
		glyphWe = 1'b0;
		textWaddr = addressPointer;
		textWdata = cmdByte;
		unique case (state)
			ST_CLEAR: begin
				textWe = 1'b1;
				textWaddr = clearIdx;
				textWdata = SPACE_CODE;
				next_clearIdx = clearIdx + 7'h1;
				if (clearIdx == CLEAR_LAST) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (rdFinish) begin
					next_addressPointer = stepPtr(addressPointer, incMode, glyphSel);
				end else if (bufOutValid && registerSelect) begin
					next_addressPointer = stepPtr(addressPointer, incMode, glyphSel);
					if (glyphSel) begin
						glyphWe = 1'b1;
					end else begin
						textWe = 1'b1;
						if (shiftEn) begin
							next_displayShift = stepShift(displayShift, incMode);
						end
					end
				end else if (bufOutValid) begin
					casez (cmdByte)
						8'b1???????: begin
							next_addressPointer = cmdByte[6:0];
							next_glyphSel = 1'b0;
						end
						8'b01??????: begin
							next_addressPointer = {1'b0, cmdByte[5:0]};
							next_glyphSel = 1'b1;
						end
						8'b001?????: begin
							next_busWidthSelect = cmdByte[4];
							next_lineCount = cmdByte[3];
							next_brightness = cmdByte[1:0];
						end
						8'b0001????: begin
							// Step by text wrap even when leaving glyph memory
							next_addressPointer = stepPtr(addressPointer, cmdByte[2], 1'b0);
							next_glyphSel = 1'b0;
							if (cmdByte[3]) begin
								next_displayShift = stepShift(displayShift, !cmdByte[2]);
							end
						end
						8'b00001???: begin
							next_displayOn = cmdByte[2];
							next_cursorOn = cmdByte[1];
							next_blinkOn = cmdByte[0];
						end
						8'b000001??: begin
							next_incMode = cmdByte[1];
							next_shiftEn = cmdByte[0];
						end
						8'b0000001?: begin
							next_addressPointer = HOME_ADDR;
							next_glyphSel = 1'b0;
							next_displayShift = 6'h0;
						end
						8'b00000001: begin
							next_state = ST_CLEAR;
							next_clearIdx = 7'h0;
							next_addressPointer = HOME_ADDR;
							next_glyphSel = 1'b0;
							next_displayShift = 6'h0;
							next_incMode = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Blink divider and cell renderer
	// ----------------------------------------------------------------
	logic [6:0] colSum, cellAddr;
	logic [7:0] cellCode;
	logic [4:0] glyphRow;
	logic atCursor, userGlyph;

	always_comb begin
		colSum = {2'b0, scanCol} + {1'b0, displayShift};
		if (colSum > {1'b0, LAST_CELL}) begin
			colSum = colSum - 7'h28;
		end
		cellAddr = {scanLine, colSum[5:0]};
		cellCode = textRam[cellAddr];
		userGlyph = (cellCode[7:4] == 4'h0);
		glyphRow = glyphRam[{cellCode[2:0], scanRow}][4:0];
		atCursor = !glyphSel && (cellAddr == addressPointer);
		next_blinkCnt = blinkCnt + 32'h1;
		next_blinkPhase = blinkPhase;
		if (blinkCnt == 32'(BLINK_HALF - 1)) begin
			next_blinkCnt = 32'h0;
			next_blinkPhase = !blinkPhase;
		end
		next_fontCode = cellCode;
		next_fontLookup = 1'b0;
		next_pixelRow = 5'h0;
		if (!displayOn) begin
			next_pixelRow = 5'h0;
		end else if (blinkOn && blinkPhase && atCursor) begin
			next_pixelRow = ALL_PIXELS;
		end else if (cursorOn && atCursor && scanRow == CURSOR_ROW) begin
			next_pixelRow = ALL_PIXELS;
		end else if (userGlyph) begin
			next_pixelRow = glyphRow;
		end else begin
			next_fontLookup = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset starts in the clear sweep so text memory fills with spaces
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_CLEAR;
			clearIdx <= 7'h0;
			addressPointer <= HOME_ADDR;
			glyphSel <= 1'b0;
			incMode <= RST_INC;
			shiftEn <= RST_SHIFT_EN;
			displayOn <= RST_DISP;
			cursorOn <= RST_CURSOR;
			blinkOn <= RST_BLINK;
			busWidthSelect <= RST_BUS_W;
			lineCount <= RST_LINES;
			brightness <= RST_BRIGHT;
			displayShift <= 6'h0;
			rdDone <= 1'b0;
			prdata <= 32'h0;
			blinkCnt <= 32'h0;
			blinkPhase <= 1'b0;
			pixelRow <= 5'h0;
			fontCode <= 8'h0;
			fontLookup <= 1'b0;
		end else begin
			state <= next_state;
			clearIdx <= next_clearIdx;
			addressPointer <= next_addressPointer;
			glyphSel <= next_glyphSel;
			incMode <= next_incMode;
			shiftEn <= next_shiftEn;
			displayOn <= next_displayOn;
			cursorOn <= next_cursorOn;
			blinkOn <= next_blinkOn;
			busWidthSelect <= next_busWidthSelect;
			lineCount <= next_lineCount;
			brightness <= next_brightness;
			displayShift <= next_displayShift;
			rdDone <= next_rdDone;
			prdata <= next_prdata;
			blinkCnt <= next_blinkCnt;
			blinkPhase <= next_blinkPhase;
			pixelRow <= next_pixelRow;
			fontCode <= next_fontCode;
			fontLookup <= next_fontLookup;
		end
	end

	always_ff @(posedge clk) begin
		if (textWe) begin
			textRam[textWaddr] <= textWdata;
		end
		if (glyphWe) begin
			glyphRam[addressPointer[5:0]] <= cmdByte;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic popInstr, popData;
	assign popInstr = (state == ST_IDLE) && bufOutValid && !registerSelect;
	assign popData = (state == ST_IDLE) && bufOutValid && registerSelect;

	clear_entry_a: assert property (popInstr && cmdByte == 8'h01 |=> state == ST_CLEAR
		&& addressPointer == HOME_ADDR && incMode && displayShift == 6'h0)
		else $error("clear did not start correctly");
	clear_length_a: assert property ($rose(state == ST_CLEAR) |-> ##127 state == ST_CLEAR
		##1 state == ST_IDLE) else $error("clear sweep length wrong");
	home_return_a: assert property (popInstr && cmdByte[7:1] == 7'h01
		|=> addressPointer == 7'h0 && !glyphSel && displayShift == 6'h0)
		else $error("home failed");
	entry_mode_a: assert property (popInstr && cmdByte[7:2] == 6'h01 |=>
		incMode == $past(cmdByte[1]) && shiftEn == $past(cmdByte[0]))
		else $error("entry mode not stored");
	glyph_wrap_a: assert property (popData && glyphSel && incMode && addressPointer == 7'h3f
		|=> addressPointer == 7'h00) else $error("glyph pointer wrap wrong");
	text_wrap_a: assert property (popData && !glyphSel && !incMode
		&& addressPointer == 7'h40 |=> addressPointer == 7'h27)
		else $error("text pointer wrap wrong");
	shift_text_a: assert property (popInstr && cmdByte[7:4] == 4'h1 |=> !glyphSel)
		else $error("shift left glyph memory selected");
	write_shift_a: assert property (popData && !glyphSel && shiftEn && incMode
		&& displayShift == 6'h0 |=> displayShift == 6'h1)
		else $error("write shift wrong");
	ptr_read_a: assert property (rdAccess && isInstr && pready |->
		prdata[7:0] == {1'b0, addressPointer}) else $error("pointer read wrong");
	display_blank_a: assert property (!displayOn |=> pixelRow == 5'h0 && !fontLookup)
		else $error("display off not blank");
	cursor_row_a: assert property (displayOn && cursorOn && atCursor && scanRow == 3'h7
		&& !(blinkOn && blinkPhase) |=> pixelRow == 5'h1f) else $error("cursor row missing");
	glyph_addr_a: assert property (popInstr && cmdByte[7:6] == 2'b01 |=> glyphSel
		&& addressPointer == {1'b0, $past(cmdByte[5:0])}) else $error("glyph address load");

	clear_c: cover property (state == ST_CLEAR ##1 state == ST_IDLE);
	glyph_write_c: cover property (popData && glyphSel);
	stall_c: cover property (bufInValid && !bufInReady);
	blink_c: cover property (blinkOn && $rose(blinkPhase));
endmodule // ccd_decoder

// ### hw/ccd_pkg.sv
// Shared constants for the character display command decoder
package ccd_pkg;
	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_INSTR = 12'h000;
	localparam logic [11:0] ADDR_DATA = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;

	// ----------------------------------------------------------------
	// Status register field positions
	// ----------------------------------------------------------------
	localparam int STAT_PTR_LSB = 0;
	localparam int STAT_GLYPH_SEL = 7;
	localparam int STAT_INC = 8;
	localparam int STAT_SHIFT_EN = 9;
	localparam int STAT_DISP = 10;
	localparam int STAT_CURSOR = 11;
	localparam int STAT_BLINK = 12;
	localparam int STAT_BUS_W = 13;
	localparam int STAT_LINES = 14;
	localparam int STAT_BRIGHT_LSB = 15;
	localparam int STAT_SHIFT_LSB = 17;

	// ----------------------------------------------------------------
	// Memories and addresses
	// ----------------------------------------------------------------
	localparam int TEXT_DEPTH = 128;
	localparam int GLYPH_DEPTH = 64;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [6:0] HOME_ADDR = 7'h00;
	localparam logic [6:0] TEXT_L1_FIRST = 7'h00;
	localparam logic [6:0] TEXT_L1_LAST = 7'h27;
	localparam logic [6:0] TEXT_L2_FIRST = 7'h40;
	localparam logic [6:0] TEXT_L2_LAST = 7'h67;
	localparam logic [6:0] CLEAR_LAST = 7'h7f;
	localparam logic [5:0] LAST_CELL = 6'h27;
	localparam logic [2:0] CURSOR_ROW = 3'h7;
	localparam logic [4:0] ALL_PIXELS = 5'h1f;
	localparam logic BUSY_FLAG = 1'b0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic RST_INC = 1'b1;
	localparam logic RST_SHIFT_EN = 1'b0;
	localparam logic RST_DISP = 1'b0;
	localparam logic RST_CURSOR = 1'b0;
	localparam logic RST_BLINK = 1'b0;
	localparam logic RST_BUS_W = 1'b1;
	localparam logic RST_LINES = 1'b1;
	localparam logic [1:0] RST_BRIGHT = 2'h0;

	// ----------------------------------------------------------------
	// Timing and buffer shape
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BUF_WIDTH = 9;
	localparam int BUF_DEPTH = 2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CLEAR = 2'b10
	} ccd_state_e;
endpackage

// ### hw/ccd_buffer.sv
// Small valid/ready FIFO between the host port and the decoder
`timescale 1ns/1ns
module ccd_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic [CW-1:0] count;
	logic [PW-1:0] next_wrPtr;
	logic [PW-1:0] next_rdPtr;
	logic [CW-1:0] next_count;
	logic push;
	logic pop;

	assign inReady = (count != CW'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];

	always_comb begin
		push = inValid && inReady;
		pop = outValid && outReady;
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		next_count = count;
		if (push) begin
			next_wrPtr = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
		end
		if (pop) begin
			next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
		end
		if (push && !pop) begin
			next_count = count + CW'(1);
		end else if (pop && !push) begin
			next_count = count - CW'(1);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
		end
	end

	// Storage needs no reset; empty slots are never read out as valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end
endmodule // ccd_buffer

// ### sim/ccd_host.sv
// Host processor model issuing APB transfers to the decoder
`timescale 1ns/1ns
module ccd_host (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ccd_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	import ccd_pkg::*;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// ----------------------------------------------------------------
	// One transfer; entered right after a rising edge
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Judged at the rising edge, with the values the slave itself sees there
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge keeps the next setup out of this time step
		@(posedge clk);
	endtask
endmodule // ccd_host

// ### sim/char_display_command_decoder_tb.sv
// Self-checking bench for the character display command decoder
`timescale 1ns/1ns
module char_display_command_decoder_tb;
	import ccd_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0] scanCol = '0;
	logic scanLine = 1'b0;
	logic [2:0] scanRow = '0;
	logic [4:0] pixelRow;
	logic [7:0] fontCode;
	logic fontLookup, busWidthSelect, lineCount, brightnessHigh, brightnessLow;
	int fail_count = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;
	ccd_host ccd_host_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr);
	ccd_decoder #(.BLINK_HALF(8)) ccd_decoder_inst (.clk, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .scanCol, .scanLine,
		.scanRow, .pixelRow, .fontCode, .fontLookup, .busWidthSelect, .lineCount,
		.brightnessHigh, .brightnessLow);
	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		ccd_host_inst.xfer(1'b1, a, {24'h0, d}, q, e);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
		logic e;
		ccd_host_inst.xfer(1'b0, a, 32'h0, q, e);
	endtask
	task automatic ins(input logic [7:0] d);
		wr(ADDR_INSTR, d);
	endtask
	task automatic ptrIs(input logic [6:0] p);
		logic [31:0] q;
		rd(ADDR_INSTR, q);
		chk(q[7:0], {BUSY_FLAG, p});
	endtask
	task automatic datIs(input logic [7:0] e);
		logic [31:0] q;
		rd(ADDR_DATA, q);
		chk(q[7:0], e);
	endtask
	task automatic stat(input int lsb, input int w, input logic [31:0] e);
		logic [31:0] q;
		rd(ADDR_STATUS, q);
		chk((q >> lsb) & ((32'h1 << w) - 32'h1), e);
	endtask
	task automatic pix(input logic [4:0] c, input logic [2:0] r, input logic [4:0] e);
		scanCol <= c;
		scanRow <= r;
		@(posedge clk);
		@(negedge clk);
		chk(pixelRow, e);
		@(posedge clk);
	endtask
	// Registered outputs settle after the edge, so they are read mid-cycle
	task automatic fnIs(input logic [3:0] e);
		@(negedge clk);
		chk({busWidthSelect, lineCount, brightnessHigh, brightnessLow}, e);
		@(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		fnIs(4'hc);
		stat(STAT_INC, 5, 5'h01);
		ptrIs(7'h00);
		datIs(SPACE_CODE);
	endtask
	task automatic t_glyph;
		ins(8'h58);
		wr(ADDR_DATA, 8'he5);
		wr(ADDR_DATA, 8'h0a);
		ptrIs(7'h1a);
		ins(8'h0c);
		ins(8'h80);
		wr(ADDR_DATA, 8'h0b);
		pix(5'h00, 3'h0, 5'h05);
		pix(5'h00, 3'h1, 5'h0a);
		ins(8'h08);
		pix(5'h00, 3'h1, 5'h00);
	endtask
	task automatic t_wrap;
		ins(8'ha7);
		wr(ADDR_DATA, 8'h41);
		ptrIs(7'h40);
		ins(8'he7);
		wr(ADDR_DATA, 8'h42);
		ptrIs(7'h00);
		ins(8'h04);
		ins(8'hc0);
		wr(ADDR_DATA, 8'h43);
		ptrIs(7'h27);
		ins(8'ha7);
		datIs(8'h41);
		ins(8'h40);
		wr(ADDR_DATA, 8'h44);
		ptrIs(7'h3f);
		ins(8'h06);
		wr(ADDR_DATA, 8'h45);
		ptrIs(7'h00);
	endtask
	task automatic t_shift;
		ins(8'h45);
		ins(8'h14);
		ptrIs(7'h06);
		stat(STAT_GLYPH_SEL, 1, 0);
		ins(8'h1c);
		stat(STAT_SHIFT_LSB, 6, 39);
		ins(8'h10);
		ptrIs(7'h06);
		ins(8'h18);
		stat(STAT_SHIFT_LSB, 6, 0);
		ins(8'h80);
		ins(8'h07);
		wr(ADDR_DATA, 8'h41);
		stat(STAT_SHIFT_LSB, 6, 1);
		datIs(8'h20);
		stat(STAT_SHIFT_LSB, 6, 1);
	endtask
	task automatic t_homeClear;
		ins(8'h06);
		ins(8'h85);
		wr(ADDR_DATA, 8'h33);
		ins(8'h03);
		ptrIs(7'h00);
		stat(STAT_SHIFT_LSB, 6, 0);
		ins(8'h85);
		datIs(8'h33);
		ins(8'h04);
		ins(8'h01);
		stat(STAT_INC, 2, 2'h1);
		ptrIs(7'h00);
		ins(8'h85);
		datIs(SPACE_CODE);
		ins(8'h58);
		datIs(8'he5);
	endtask
	task automatic t_cursorFunc;
		logic [31:0] q;
		logic e;
		ins(8'h0e);
		ins(8'h80);
		pix(5'h00, 3'h7, ALL_PIXELS);
		pix(5'h00, 3'h6, 5'h00);
		@(negedge clk);
		chk({fontLookup, fontCode}, {1'b1, SPACE_CODE});
		@(posedge clk);
		ins(8'h23);
		fnIs(4'h3);
		ins(8'h3c);
		fnIs(4'hc);
		ccd_host_inst.xfer(1'b0, 12'h0fc, 32'h0, q, e);
		chk(e, 1'b1);
	endtask
	// Any sixteen cycles in a row hold eight of each blink phase
	task automatic t_blink;
		int lit = 0;
		int dark = 0;
		ins(8'h0d);
		scanCol <= 5'h00;
		scanRow <= 3'h0;
		@(posedge clk);
		repeat (16) begin
			@(negedge clk);
			lit += (pixelRow == ALL_PIXELS);
			dark += (pixelRow == 5'h00);
		end
		@(posedge clk);
		chk(lit, 8);
		chk(dark, 8);
		ins(8'hc1);
		wr(ADDR_DATA, 8'h0b);
		scanLine <= 1'b1;
		pix(5'h01, 3'h1, 5'h0a);
	endtask
	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_glyph();
		t_wrap();
		t_shift();
		t_homeClear();
		t_cursorFunc();
		t_blink();
		summarize();
	end
	// Generous bound: 69 transfers plus two clear sweeps, 20000 cycles
	initial begin
		#200000;
		fail_count++;
		summarize();
	end
endmodule // char_display_command_decoder_tb
